/* shared/isamc_regs.vh */
// Timing constants of the expansion bus master cycle sequencer
`ifndef ISAMC_REGS_VH
`define ISAMC_REGS_VH

// Least spacings, in T (one period of the double-rate bus clock)
`define ISAMC_T_LA_BEFORE_ALE_OFF   5
`define ISAMC_T_LA_BEFORE_CMD_ON    5
`define ISAMC_T_SA_BEFORE_ALE_OFF   1
`define ISAMC_T_SA_BEFORE_CMD_ON    2
`define ISAMC_T_ALE_MIN_WIDTH       1
`define ISAMC_T_ALE_ON_TO_CMD_ON    2
`define ISAMC_T_ALE_OFF_TO_LA_OFF   14
`define ISAMC_T_ALE_ON_TO_CMD_OFF   11
`define ISAMC_T_CMD_ON_TO_LA_OFF    13
`define ISAMC_T_CMD_MIN_WIDTH       9
`define ISAMC_T_CMD_ON_TO_SA_OFF    10
`define ISAMC_T_CMD_OFF_TO_ALE_ON   1

// Chosen placement of ALE assertion and its width inside a cycle
`define ISAMC_T_ALE_ON_MARK         4
`define ISAMC_T_ALE_WIDTH           1

// Core clock cycles per T
`define ISAMC_CORE_PER_T            3

// Reset values of the active-low strobes and the bus clock
`define ISAMC_STROBE_IDLE           1'h1
`define ISAMC_BUSCLK_RESET          1'h0

`endif

/* design/isamc_tick_gen.v */
// Double-rate bus clock divider and T-period tick
`timescale 1ns/1ps
`default_nettype none
`include "isamc_regs.vh"

module isamc_tick_gen #(
    parameter integer CORE_PER_T = `ISAMC_CORE_PER_T
) (
    input  wire       core_clk,
    input  wire       srst,
    output reg        tTick,
    output reg        busClk
);

    reg  [7:0] divCount_reg;
    wire       wrapNow;

    assign wrapNow = (divCount_reg == CORE_PER_T[7:0] - 8'h01);

    // Divider; one tick per T and the bus clock rises with it
    always @(posedge core_clk) begin
        if (srst) begin
            divCount_reg <= 8'h00;
            tTick        <= 1'b0;
            busClk       <= `ISAMC_BUSCLK_RESET;
        end else begin
            divCount_reg <= wrapNow ? 8'h00 : divCount_reg + 8'h01;
            tTick        <= wrapNow;
            if (wrapNow) begin
                busClk <= 1'b1;
            end else if (divCount_reg == (CORE_PER_T[7:0] >> 1)) begin
                busClk <= 1'b0;
            end
        end
    end

endmodule // isamc_tick_gen

`default_nettype wire

/* design/isamc_tick_sampler.v */
// Group sampler that captures a bus once per T
`timescale 1ns/1ps
`default_nettype none

module isamc_tick_sampler #(
    parameter integer WIDTH = 4
) (
    input  wire             core_clk,
    input  wire             srst,
    input  wire             tTick,
    input  wire [WIDTH-1:0] groupIn,
    output reg  [WIDTH-1:0] groupOut
);

    // Capture on the T edge only
    always @(posedge core_clk) begin
        if (srst) begin
            groupOut <= {WIDTH{1'b0}};
        end else if (tTick) begin
            groupOut <= groupIn;
        end
    end

endmodule // isamc_tick_sampler

`default_nettype wire

/* design/isamc_master_seq.v */
// Expansion bus master cycle sequencer with multiplexed IPC lines
//
// Contract
// - LA valid 5T before ALE negated
// - LA valid 5T before memory command
// - SA and SBHE valid 1T before ALE negated
// - SA valid 2T before memory command
// - SA valid 2T before I/O command
// - ALE asserted at least 1T
// - ALE asserted 2T before any command
// - LA held 14T after ALE negated
// - Memory command negated 11T after ALE on
// - LA held 13T after memory command
// - Memory command strobes held at least 9T
// - I/O command strobes held at least 9T
// - SA held 10T after memory command
// - DMA ack code and TC on bus clock
`timescale 1ns/1ps
`default_nettype none
`include "isamc_regs.vh"

module isamc_master_seq #(
    parameter integer CORE_PER_T = `ISAMC_CORE_PER_T,
    parameter integer IRQ_W      = 4,
    parameter integer DREQ_W     = 2,
    parameter integer DACK_W     = 3
) (
    input  wire              core_clk,
    input  wire              srst,
    // Cycle request from the core side
    input  wire              reqValid,
    input  wire              reqIsIo,
    input  wire              reqWrite,
    input  wire              reqLowMeg,
    input  wire [23:0]       reqAddr,
    input  wire              reqByteHigh,
    output reg               reqReady,
    output reg               cycleDone,
    // Bus address and strobes
    output reg  [6:0]        laOut,
    output reg               laOe,
    output reg  [19:0]       saOut,
    output reg               sbheN,
    output reg               saOe,
    output reg               aleN,
    output reg               memrN,
    output reg               memwN,
    output reg               smemrN,
    output reg               smemwN,
    output reg               iorN,
    output reg               iowN,
    output reg               double_rate_bus_clock,
    // Multiplexed IPC lines
    input  wire [DACK_W-1:0] dmaAckCodeCore,
    input  wire              termCountCore,
    output reg  [DACK_W-1:0] dma_acknowledge_code,
    output reg               termCountOut,
    input  wire [IRQ_W-1:0]  interrupt_request_group_in,
    input  wire [DREQ_W-1:0] dma_request_group_in,
    output reg  [IRQ_W-1:0]  irqGroupSampled,
    output reg  [DREQ_W-1:0] dreqGroupSampled
);

    // Cycle marks in T, counted from the start of address drive
    localparam integer ALE_ON_I  = `ISAMC_T_ALE_ON_MARK;
    localparam integer ALE_W_I   = (`ISAMC_T_ALE_WIDTH > `ISAMC_T_ALE_MIN_WIDTH) ?
                                   `ISAMC_T_ALE_WIDTH : `ISAMC_T_ALE_MIN_WIDTH;
    localparam integer ALE_OFF_A = ALE_ON_I + ALE_W_I;
    localparam integer ALE_OFF_B = (`ISAMC_T_LA_BEFORE_ALE_OFF > `ISAMC_T_SA_BEFORE_ALE_OFF) ?
                                   `ISAMC_T_LA_BEFORE_ALE_OFF : `ISAMC_T_SA_BEFORE_ALE_OFF;
    localparam integer ALE_OFF_I = (ALE_OFF_A > ALE_OFF_B) ? ALE_OFF_A : ALE_OFF_B;
    localparam integer CMD_ON_A  = ALE_ON_I + `ISAMC_T_ALE_ON_TO_CMD_ON;
    localparam integer CMD_ON_B  = (`ISAMC_T_LA_BEFORE_CMD_ON > `ISAMC_T_SA_BEFORE_CMD_ON) ?
                                   `ISAMC_T_LA_BEFORE_CMD_ON : `ISAMC_T_SA_BEFORE_CMD_ON;
    localparam integer CMD_ON_I  = (CMD_ON_A > CMD_ON_B) ? CMD_ON_A : CMD_ON_B;
    localparam integer CMD_OFF_A = CMD_ON_I + `ISAMC_T_CMD_MIN_WIDTH;
    localparam integer CMD_OFF_B = ALE_ON_I + `ISAMC_T_ALE_ON_TO_CMD_OFF;
    localparam integer CMD_OFF_I = (CMD_OFF_A > CMD_OFF_B) ? CMD_OFF_A : CMD_OFF_B;
    localparam integer LA_OFF_A  = ALE_OFF_I + `ISAMC_T_ALE_OFF_TO_LA_OFF;
    localparam integer LA_OFF_B  = CMD_ON_I + `ISAMC_T_CMD_ON_TO_LA_OFF;
    localparam integer LA_OFF_C  = (LA_OFF_A > LA_OFF_B) ? LA_OFF_A : LA_OFF_B;
    localparam integer SA_OFF_A  = CMD_ON_I + `ISAMC_T_CMD_ON_TO_SA_OFF;
    localparam integer LA_OFF_I  = (LA_OFF_C > SA_OFF_A) ? LA_OFF_C : SA_OFF_A;
    localparam integer END_I     = LA_OFF_I + `ISAMC_T_CMD_OFF_TO_ALE_ON;

    localparam [5:0] MARK_ALE_ON  = ALE_ON_I[5:0];
    localparam [5:0] MARK_ALE_OFF = ALE_OFF_I[5:0];
    localparam [5:0] MARK_CMD_ON  = CMD_ON_I[5:0];
    localparam [5:0] MARK_CMD_OFF = CMD_OFF_I[5:0];
    localparam [5:0] MARK_ADR_OFF = LA_OFF_I[5:0];
    localparam [5:0] MARK_END     = END_I[5:0];

    // One-hot sequencer states
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_ALE  = 6'h04;
    localparam [5:0] ST_CMD  = 6'h08;
    localparam [5:0] ST_HOLD = 6'h10;
    localparam [5:0] ST_RECV = 6'h20;

    wire              tTick;
    wire              busClkDiv;
    wire [IRQ_W-1:0]  irqSampled;
    wire [DREQ_W-1:0] dreqSampled;

    reg  [5:0]        state_reg;
    reg  [5:0]        state_next;
    reg  [5:0]        pos_reg;
    reg  [5:0]        pos_next;
    reg               isIo_reg;
    reg               isWrite_reg;
    reg               lowMeg_reg;
    wire              cmdActive;

    // T tick and the double-rate bus clock
    isamc_tick_gen #(
        .CORE_PER_T (CORE_PER_T)
    ) u_tick (
        .core_clk (core_clk),
        .srst     (srst),
        .tTick    (tTick),
        .busClk   (busClkDiv)
    );

    // Interrupt group taken once per T
    isamc_tick_sampler #(
        .WIDTH (IRQ_W)
    ) u_irq_smp (
        .core_clk (core_clk),
        .srst     (srst),
        .tTick    (tTick),
        .groupIn  (interrupt_request_group_in),
        .groupOut (irqSampled)
    );

    // DMA request group taken once per T
    isamc_tick_sampler #(
        .WIDTH (DREQ_W)
    ) u_dreq_smp (
        .core_clk (core_clk),
        .srst     (srst),
        .tTick    (tTick),
        .groupIn  (dma_request_group_in),
        .groupOut (dreqSampled)
    );

    // Next position and state; all marks counted in T
    always @* begin
        state_next = state_reg;
        pos_next   = pos_reg;
        if (tTick) begin
            case (state_reg)
                ST_IDLE: begin
                    if (reqValid) begin
                        state_next = ST_ADDR;
                        pos_next   = 6'h00;
                    end
                end
                ST_ADDR: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_next == MARK_ALE_ON) begin
                        state_next = ST_ALE;
                    end
                end
                ST_ALE: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_next == MARK_CMD_ON) begin
                        state_next = ST_CMD;
                    end
                end
                ST_CMD: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_next == MARK_CMD_OFF) begin
                        state_next = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_next == MARK_ADR_OFF) begin
                        state_next = ST_RECV;
                    end
                end
                ST_RECV: begin
                    pos_next = pos_reg + 6'h01;
                    if (pos_next == MARK_END) begin
                        state_next = ST_IDLE;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    pos_next   = 6'h00;
                end
            endcase
        end
    end

    // State, position and request attributes
    always @(posedge core_clk) begin
        if (srst) begin
            state_reg   <= ST_IDLE;
            pos_reg     <= 6'h00;
            isIo_reg    <= 1'b0;
            isWrite_reg <= 1'b0;
            lowMeg_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            pos_reg   <= pos_next;
            if (state_reg == ST_IDLE && tTick && reqValid) begin
                isIo_reg    <= reqIsIo;
                isWrite_reg <= reqWrite;
                lowMeg_reg  <= reqLowMeg;
            end
        end
    end

    assign cmdActive = (state_next == ST_CMD);

    // Request handshake flags
    always @(posedge core_clk) begin
        if (srst) begin
            reqReady  <= 1'b0;
            cycleDone <= 1'b0;
        end else begin
            reqReady  <= (state_next == ST_IDLE);
            cycleDone <= (state_reg == ST_RECV) && (state_next == ST_IDLE);
        end
    end

    // Address drive: LA and SA from start until both holds expire
    always @(posedge core_clk) begin
        if (srst) begin
            laOut <= 7'h00;
            laOe  <= 1'b0;
            saOut <= 20'h00000;
            sbheN <= `ISAMC_STROBE_IDLE;
            saOe  <= 1'b0;
        end else if (state_reg == ST_IDLE && state_next == ST_ADDR) begin
            laOut <= reqAddr[23:17];
            laOe  <= 1'b1;
            saOut <= reqAddr[19:0];
            sbheN <= ~reqByteHigh;
            saOe  <= 1'b1;
        end else if (state_next == ST_RECV || state_next == ST_IDLE) begin
            laOe  <= 1'b0;
            saOe  <= 1'b0;
            sbheN <= `ISAMC_STROBE_IDLE;
        end
    end

    // ALE: asserted at its mark for its width
    always @(posedge core_clk) begin
        if (srst) begin
            aleN <= `ISAMC_STROBE_IDLE;
        end else if (state_next == ST_ADDR || state_next == ST_IDLE) begin
            aleN <= `ISAMC_STROBE_IDLE;
        end else if (tTick && pos_next == MARK_ALE_ON) begin
            aleN <= 1'b0;
        end else if (tTick && pos_next == MARK_ALE_OFF) begin
            aleN <= `ISAMC_STROBE_IDLE;
        end
    end

    // Command strobes: one of memrN, memwN, iorN, iowN, or memrN/memwN with smemrN/smemwN on low-meg cycles, held between the command marks
    always @(posedge core_clk) begin
        if (srst) begin
            memrN  <= `ISAMC_STROBE_IDLE;
            memwN  <= `ISAMC_STROBE_IDLE;
            smemrN <= `ISAMC_STROBE_IDLE;
            smemwN <= `ISAMC_STROBE_IDLE;
            iorN   <= `ISAMC_STROBE_IDLE;
            iowN   <= `ISAMC_STROBE_IDLE;
        end else begin
            memrN  <= ~(cmdActive && !isIo_reg && !isWrite_reg);
            memwN  <= ~(cmdActive && !isIo_reg && isWrite_reg);
            smemrN <= ~(cmdActive && !isIo_reg && !isWrite_reg && lowMeg_reg);
            smemwN <= ~(cmdActive && !isIo_reg && isWrite_reg && lowMeg_reg);
            iorN   <= ~(cmdActive && isIo_reg && !isWrite_reg);
            iowN   <= ~(cmdActive && isIo_reg && isWrite_reg);
        end
    end

    // IPC lines re-timed to the T edge
    always @(posedge core_clk) begin
        if (srst) begin
            dma_acknowledge_code  <= {DACK_W{1'b0}};
            termCountOut          <= 1'b0;
            irqGroupSampled       <= {IRQ_W{1'b0}};
            dreqGroupSampled      <= {DREQ_W{1'b0}};
            double_rate_bus_clock <= `ISAMC_BUSCLK_RESET;
        end else begin
            double_rate_bus_clock <= busClkDiv;
            irqGroupSampled       <= irqSampled;
            dreqGroupSampled      <= dreqSampled;
            if (tTick) begin
                dma_acknowledge_code <= dmaAckCodeCore;
                termCountOut         <= termCountCore;
            end
        end
    end

endmodule // isamc_master_seq

`default_nettype wire

/* testbench/isamc_master_seq_assertions.sv */
// Checker of the bus cycle spacings of the master sequencer
`timescale 1ns/1ps
`default_nettype none
module isamc_master_seq_assertions #(
    parameter integer CORE_PER_T = 3,
    parameter integer DACK_W     = 3
) (
    input wire logic              core_clk,
    input wire logic              srst,
    input wire logic              laOe,
    input wire logic              saOe,
    input wire logic              aleN,
    input wire logic              memrN,
    input wire logic              memwN,
    input wire logic              smemrN,
    input wire logic              smemwN,
    input wire logic              iorN,
    input wire logic              iowN,
    input wire logic              double_rate_bus_clock,
    input wire logic [DACK_W-1:0] dma_acknowledge_code,
    input wire logic              termCountOut
);
    localparam integer P = CORE_PER_T;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire memLow = !(memrN && memwN && smemrN && smemwN);
    wire ioLow  = !(iorN && iowN);
    wire cmdLow = memLow || ioLow;
    logic [31:0] cyc, tAleOn, tAleOff, tCmdOn, tLa, tSa;
    logic        aleD, cmdD, laD, saD;
    // Time stamps of both ALE edges and of the latest start of command, LA and SA drive
    always @(posedge core_clk) begin
        cyc  <= srst ? 32'h0 : cyc + 32'h1;
        aleD <= aleN;
        cmdD <= cmdLow;
        laD  <= laOe;
        saD  <= saOe;
        if (aleD && !aleN) tAleOn <= cyc;
        if (!aleD && aleN) tAleOff <= cyc;
        if (!cmdD && cmdLow) tCmdOn <= cyc;
        if (!laD && laOe) tLa <= cyc;
        if (!saD && saOe) tSa <= cyc;
    end
    la_before_ale_a: assert property ($rose(aleN) |-> cyc - tLa >= 5 * P) else $error("LA lead to ALE end");
    la_before_mem_a: assert property ($rose(memLow) |-> cyc - tLa >= 5 * P) else $error("LA lead to command");
    sa_before_ale_a: assert property ($rose(aleN) |-> cyc - tSa >= P) else $error("SA lead to ALE end");
    sa_before_cmd_a: assert property ($rose(cmdLow) |-> cyc - tSa >= 2 * P) else $error("SA lead");
    ale_width_a: assert property ($rose(aleN) |-> cyc - tAleOn >= P) else $error("ALE too short");
    ale_to_cmd_a: assert property ($rose(cmdLow) |-> cyc - tAleOn >= 2 * P) else $error("ALE to command");
    la_after_ale_a: assert property ($fell(laOe) |-> cyc - tAleOff >= 14 * P) else $error("LA hold");
    mem_after_ale_a: assert property ($fell(memLow) |-> cyc - tAleOn >= 11 * P) else $error("early end");
    la_after_cmd_a: assert property ($fell(laOe) |-> cyc - tCmdOn >= 13 * P) else $error("LA hold");
    mem_width_a: assert property ($fell(memLow) |-> cyc - tCmdOn >= 9 * P) else $error("mem width");
    io_width_a: assert property ($fell(ioLow) |-> cyc - tCmdOn >= 9 * P) else $error("I/O width");
    sa_after_cmd_a: assert property ($fell(saOe) |-> cyc - tCmdOn >= 10 * P) else $error("SA hold");
    ipc_on_clock_a: assert property ($changed({termCountOut, dma_acknowledge_code})
        |-> $rose(double_rate_bus_clock)) else $error("IPC out off clock");
    // Main kinds of cycle
    cover property ($fell(memrN));
    cover property ($fell(smemwN));
    cover property ($fell(iowN));
endmodule // isamc_master_seq_assertions
bind isamc_master_seq isamc_master_seq_assertions #(.CORE_PER_T(CORE_PER_T), .DACK_W(DACK_W))
    isamc_master_seq_assertions_i (.core_clk, .srst, .laOe, .saOe, .aleN, .memrN, .memwN, .smemrN, .smemwN,
    .iorN, .iowN, .double_rate_bus_clock, .dma_acknowledge_code, .termCountOut);
`default_nettype wire

/* testbench/isamc_slave_model.sv */
// Slave side model presenting the multiplexed request groups
`timescale 1ns/1ps
`default_nettype none
module isamc_slave_model (
    input  wire logic       busClk,
    input  wire logic [3:0] irqNext,
    input  wire logic [1:0] dreqNext,
    output var  logic [3:0] irqOut,
    output var  logic [1:0] dreqOut
);
    // Groups move just after a bus clock rise and stand a whole period
    initial begin
        irqOut = 4'h0;
        dreqOut = 2'h0;
    end
    always @(posedge busClk) begin
        irqOut <= irqNext;
        dreqOut <= dreqNext;
    end
endmodule // isamc_slave_model
`default_nettype wire

/* testbench/isamc_master_seq_test.sv */
// Self-checking bench of the master cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module isamc_master_seq_test;
    localparam integer P = 3;
    logic core_clk, srst, reqValid, reqIsIo, reqWrite, reqLowMeg, reqByteHigh, reqReady, cycleDone;
    logic laOe, saOe, sbheN, aleN, memrN, memwN, smemrN, smemwN, iorN, iowN, termCountCore, termCountOut;
    logic double_rate_bus_clock, sbheCmd;
    logic laD = 1'b0, aleD = 1'b1, cmdD = 1'b0, saD = 1'b0;
    logic [23:0] reqAddr;
    logic [19:0] saOut, saCmd;
    logic [6:0]  laOut, laCmd;
    logic [5:0]  seen;
    logic [3:0]  irqNext, interrupt_request_group_in, irqGroupSampled;
    logic [2:0]  dmaAckCodeCore, dma_acknowledge_code;
    logic [1:0]  dreqNext, dma_request_group_in, dreqGroupSampled;
    int mismatches = 0, checks = 0, cyc = 0, tAddr, tRel, tAleOn, tAleOff, tCmdOn, tCmdOff, tSaOn, tSaRel;
    wire cmdLow = !(memrN && memwN && smemrN && smemwN && iorN && iowN);

    isamc_master_seq #(.CORE_PER_T(P)) isamc_master_seq_i (.core_clk, .srst, .reqValid, .reqIsIo, .reqWrite,
        .reqLowMeg, .reqAddr, .reqByteHigh, .reqReady, .cycleDone, .laOut, .laOe, .saOut, .sbheN, .saOe, .aleN,
        .memrN, .memwN, .smemrN, .smemwN, .iorN, .iowN, .double_rate_bus_clock, .dmaAckCodeCore, .termCountCore,
        .dma_acknowledge_code, .termCountOut, .interrupt_request_group_in, .dma_request_group_in,
        .irqGroupSampled, .dreqGroupSampled);
    isamc_slave_model isamc_slave_model_i (.busClk(double_rate_bus_clock), .irqNext, .dreqNext,
        .irqOut(interrupt_request_group_in), .dreqOut(dma_request_group_in));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Edge stamps, address at command start, strobes seen, hang limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        laD <= laOe;
        saD <= saOe;
        if (saOe && !saD) tSaOn <= cyc;
        if (!saOe && saD) tSaRel <= cyc;
        aleD <= aleN;
        cmdD <= cmdLow;
        if (laOe && !laD) tAddr <= cyc;
        if (!laOe && laD) tRel <= cyc;
        if (!aleN && aleD) tAleOn <= cyc;
        if (aleN && !aleD) tAleOff <= cyc;
        if (!cmdLow && cmdD) tCmdOff <= cyc;
        if (cmdLow && !cmdD) begin
            tCmdOn <= cyc;
            laCmd <= laOut;
            saCmd <= saOut;
            sbheCmd <= sbheN;
        end
        seen <= seen | ~{memrN, memwN, smemrN, smemwN, iorN, iowN};
        if (cyc > 4000) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end

    task automatic chk(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic chk_timing(input bit io);
        chk(tAleOff - tAddr >= 5 * P, "LA lead to ALE end");
        chk(io || tCmdOn - tAddr >= 5 * P, "LA lead to command");
        chk(tAleOff - tSaOn >= P, "SA lead to ALE end");
        chk(tCmdOn - tSaOn >= 2 * P, "SA lead to command");
        chk(tAleOff - tAleOn >= P, "ALE width");
        chk(tCmdOn - tAleOn >= 2 * P, "ALE to command");
        chk(tRel - tAleOff >= 14 * P, "LA hold after ALE");
        chk(io || tCmdOff - tAleOn >= 11 * P, "ALE to command end");
        chk(io || tRel - tCmdOn >= 13 * P, "LA hold after command");
        chk(tCmdOff - tCmdOn >= 9 * P, "command width");
        chk(io || tSaRel - tCmdOn >= 10 * P, "SA hold after command");
    endtask

    // One whole cycle, then its strobes, address and spacing
    task automatic do_cycle(input bit io, wr, lm, bh, input logic [23:0] a, input logic [5:0] exp);
        int n;
        @(negedge core_clk);
        {reqIsIo, reqWrite, reqLowMeg, reqByteHigh, reqAddr, seen, reqValid} = {io, wr, lm, bh, a, 6'h0, 1'b1};
        n = 0;
        while (cycleDone !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
            if (laOe === 1'b1 && reqValid === 1'b1) begin
                chk(reqReady === 1'b0, "ready while busy");
                reqValid = 1'b0;
            end
        end
        chk(n < 200, "cycle never ended");
        chk(reqReady === 1'b1, "not ready at cycle end");
        chk(seen === exp, "wrong strobes");
        chk(laCmd === a[23:17] && saCmd === a[19:0] && sbheCmd === !bh, "address");
        chk_timing(io);
    endtask

    task automatic t_reset;
        int n;
        srst = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({aleN, memrN, memwN, smemrN, smemwN, iorN, iowN, sbheN} === 8'hff && {laOe, saOe} === 2'h0, "reset");
        chk(double_rate_bus_clock === 1'b0 && cycleDone === 1'b0, "reset clock");
        srst = 1'b0;
        n = 0;
        while (reqReady !== 1'b1 && n < 3) begin
            @(negedge core_clk);
            n++;
        end
        chk(reqReady === 1'b1, "not ready after reset");
    endtask

    task automatic t_memory;
        do_cycle(1'b0, 1'b0, 1'b0, 1'b1, 24'hffffff, 6'h20);
        do_cycle(1'b0, 1'b1, 1'b0, 1'b0, 24'h000000, 6'h10);
        do_cycle(1'b0, 1'b0, 1'b1, 1'b0, 24'h0a5a5a, 6'h28);
        do_cycle(1'b0, 1'b1, 1'b1, 1'b1, 24'h15a5a5, 6'h14);
    endtask

    task automatic t_io;
        do_cycle(1'b1, 1'b0, 1'b0, 1'b1, 24'h0003f8, 6'h02);
        do_cycle(1'b1, 1'b1, 1'b1, 1'b0, 24'h0fffff, 6'h01);
    endtask

    // Request held high across two cycles; no extra cycle while busy
    task automatic t_back_to_back;
        int n, done, takes;
        @(negedge core_clk);
        {reqIsIo, reqWrite, reqLowMeg, reqValid} = 4'h1;
        {n, done, takes} = 0;
        while (done < 2 && n < 200) begin
            @(negedge core_clk);
            n++;
            if (cycleDone === 1'b1) done++;
            if (tAddr == cyc - 1 && n > 1) takes++;
        end
        reqValid = 1'b0;
        chk(done == 2 && takes == 2, "back to back count");
        chk_timing(1'b0);
        repeat (80) @(negedge core_clk);
    endtask

    // Request groups sampled, acknowledge code and terminal count passed on
    task automatic t_ipc;
        int n;
        for (int i = 0; i < 2; i++) begin
            irqNext = i ? 4'h5 : 4'ha;
            dreqNext = i ? 2'h1 : 2'h2;
            dmaAckCodeCore = i ? 3'h6 : 3'h1;
            termCountCore = !i;
            n = 0;
            while (n < 4 * P && (irqGroupSampled !== irqNext || dreqGroupSampled !== dreqNext ||
                   dma_acknowledge_code !== dmaAckCodeCore)) begin
                @(negedge core_clk);
                n++;
            end
            chk(irqGroupSampled === irqNext, "interrupt group");
            chk(dreqGroupSampled === dreqNext, "request group");
            chk(dma_acknowledge_code === dmaAckCodeCore && termCountOut === termCountCore, "ack");
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        {reqValid, reqIsIo, reqWrite, reqLowMeg, reqByteHigh, reqAddr, seen} = 0;
        {dmaAckCodeCore, termCountCore, irqNext, dreqNext} = 0;
        t_reset;
        t_memory;
        t_io;
        t_back_to_back;
        t_ipc;
        close_out;
    end
endmodule // isamc_master_seq_test
`default_nettype wire
